// *** fmt_consts.vh ***
/*
 * constants for the mode and torch current control register block:
 * register addresses, field positions, reset values, mode codes, timer figures.
 * assumes a 40 mhz system clock and a serial front end that hands over
 * decoded register writes and reads.
 */
// Summary of operation
// (RQ1) force bit set makes the converter a constant voltage source.
// (RQ2) reading the force bit returns the voltage-mode pin level.
// (RQ3) mode field: 00 shutdown, 01 torch, 10 torch plus flash, 11 voltage source.
// (RQ4) safety timer forces shutdown unless mode field is rewritten before timeout.
// (RQ5) host rewrites the mode field more often than every 11.2 s.
// (RQ6) mode field write also updates the mode copy in flash-current register.
// (RQ7) variant a outer code: 00 off, then 50, 75, 100 ma.
// (RQ8) variant a centre code: 000 off, then 50 to 250 ma.
// (RQ9) variant b outer code: 00 off, then 55, 85, 110 ma.
// (RQ10) variant b centre code: 000 off, then 55 to 275 ma.
// (RQ11) centre codes 110 and 111 allow 350 or 500 ma with transmit mask.
// (RQ12) both torch fields zero selects voltage regulation from output-voltage setting.
// (RQ13) host clears led channel enables before zeroing both torch fields.
// (RQ14) write takes effect at end of acknowledge after the data byte.
// (RQ15) zero mode field shuts down only with force bit and torch enable low.
// (RQ16) mode bits of both registers read back identically after any write.
`ifndef FMT_CONSTS_VH
`define FMT_CONSTS_VH
`define FMT_ADDR_CTRL 8'h01
`define FMT_ADDR_FLASH 8'h02
`define FMT_BIT_VMF 7
`define FMT_MODE_HI 6
`define FMT_MODE_LO 5
`define FMT_OUTER_HI 4
`define FMT_OUTER_LO 3
`define FMT_CENTRE_HI 2
`define FMT_CENTRE_LO 0
`define FMT_CTRL_RESET 8'h09
`define FMT_FLASH_RESET 8'h03
`define FMT_MODE_SHDN 2'h0
`define FMT_MODE_TORCH 2'h1
`define FMT_MODE_FLASH 2'h2
`define FMT_MODE_VSRC 2'h3
`define FMT_TIMEOUT_MS 11200
`define FMT_CLK_HZ 40000000
// safety timeout as whole clock cycles: 11.2 s at 40 mhz
`define FMT_TIMEOUT_CYC 32'h1ab3f000
`endif

// *** fmt_mode_torch_reg.v ***
/*
 * mode and torch current control register with its mode copy in the
 * flash-current register, the safety timer and the torch current decode.
 * assumes the serial front end pulses i_wr_stb at the falling edge of the
 * acknowledge that follows the data byte, and that all inputs are
 * synchronous to i_clk_sys.
 * limitation: a write to either register restarts the safety timer,
 * whatever mode it carries; a write in the expiry cycle is dropped.
 * variant b selects the second torch current table.
 * the force bit drives the outputs from its stored value only.
 */
`include "fmt_consts.vh"

module fmt_mode_torch_reg #(
    parameter VARIANT_B = 0,
    parameter [31:0] TIMEOUT_CYC = `FMT_TIMEOUT_CYC
) (
    input wire i_clk_sys,
    input wire i_srst,
    input wire i_wr_stb,
    input wire [7:0] i_wr_addr,
    input wire [7:0] i_wr_data,
    input wire [7:0] i_rd_addr,
    output reg [7:0] o_rd_data,
    input wire i_vm_pin,
    input wire i_torch_enable,
    input wire i_tx_mask,
    output reg [7:0] o_flash_reg,
    output reg o_const_voltage,
    output reg o_shutdown,
    output reg o_torch_on,
    output reg o_flash_arm,
    output reg o_vreg_mode,
    output reg [9:0] o_outer_ma,
    output reg [9:0] o_centre_ma,
    output reg o_timeout
);

    reg [7:0] ctrl_r;
    reg [7:0] ctrl_nxt;
    reg [7:0] flash_r;
    reg [7:0] flash_nxt;
    reg [31:0] timer_r;
    reg [31:0] timer_nxt;
    reg timeout_r;
    reg timeout_nxt;
    reg [7:0] rd_nxt;
    wire [1:0] mode = ctrl_r[`FMT_MODE_HI:`FMT_MODE_LO];
    wire wr_ctrl = i_wr_stb && (i_wr_addr == `FMT_ADDR_CTRL);
    wire wr_flash = i_wr_stb && (i_wr_addr == `FMT_ADDR_FLASH);
    // a write to either register counts as a mode refresh for the timer
    wire refresh = wr_ctrl || wr_flash;

    // modes in which the torch current sinks run
    function lit_mode;
        input [1:0] code;
        begin
            lit_mode = (code == `FMT_MODE_TORCH) || (code == `FMT_MODE_FLASH);
        end
    endfunction

    // outer led torch current in ma, per variant
    function [9:0] outer_ma;
        input [1:0] code;
        input vb;
        begin
            if (vb) begin
                case (code)
                    2'h1: outer_ma = 10'h037; // RQ9
                    2'h2: outer_ma = 10'h055;
                    2'h3: outer_ma = 10'h06e;
                    default: outer_ma = 10'h000;
                endcase
            end else begin
                case (code)
                    2'h1: outer_ma = 10'h032; // RQ7
                    2'h2: outer_ma = 10'h04b;
                    2'h3: outer_ma = 10'h064;
                    default: outer_ma = 10'h000;
                endcase
            end
        end
    endfunction

    // centre led torch current; top codes lift with transmit mask
    function [9:0] centre_ma;
        input [2:0] code;
        input vb;
        input txm;
        begin
            if (txm && code == 3'h6) begin
                centre_ma = 10'h15e; // RQ11
            end else if (txm && code == 3'h7) begin
                centre_ma = 10'h1f4; // RQ11
            end else if (vb) begin
                case (code)
                    3'h1: centre_ma = 10'h037; // RQ10
                    3'h2: centre_ma = 10'h055;
                    3'h3: centre_ma = 10'h06e;
                    3'h4: centre_ma = 10'h08c;
                    3'h5: centre_ma = 10'h0a5;
                    3'h6: centre_ma = 10'h0dc;
                    3'h7: centre_ma = 10'h113;
                    default: centre_ma = 10'h000;
                endcase
            end else begin
                case (code)
                    3'h1: centre_ma = 10'h032; // RQ8
                    3'h2: centre_ma = 10'h04b;
                    3'h3: centre_ma = 10'h064;
                    3'h4: centre_ma = 10'h07d;
                    3'h5: centre_ma = 10'h096;
                    3'h6: centre_ma = 10'h0c8;
                    3'h7: centre_ma = 10'h0fa;
                    default: centre_ma = 10'h000;
                endcase
            end
        end
    endfunction

    // register next values; expiry wins over a write in the same cycle
    always @* begin
        ctrl_nxt = ctrl_r;
        flash_nxt = flash_r;
        if (timeout_r) begin
            // clear the mode in both copies so reads agree
            ctrl_nxt[`FMT_MODE_HI:`FMT_MODE_LO] = `FMT_MODE_SHDN; // RQ4 RQ16
            flash_nxt[`FMT_MODE_HI:`FMT_MODE_LO] = `FMT_MODE_SHDN;
        end else if (wr_ctrl) begin
            ctrl_nxt = i_wr_data; // RQ14
            flash_nxt[`FMT_MODE_HI:`FMT_MODE_LO] = i_wr_data[`FMT_MODE_HI:`FMT_MODE_LO]; // RQ6
        end else if (wr_flash) begin
            flash_nxt = i_wr_data; // RQ14
            ctrl_nxt[`FMT_MODE_HI:`FMT_MODE_LO] = i_wr_data[`FMT_MODE_HI:`FMT_MODE_LO]; // RQ16
        end
    end

    // register state; both mode copies move together
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            ctrl_r <= `FMT_CTRL_RESET;
            flash_r <= `FMT_FLASH_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            flash_r <= flash_nxt;
        end
    end

    // safety timer: runs only in torch and flash modes, whatever the force bit, restarts on refresh
    always @* begin
        timer_nxt = timer_r + 32'h1;
        timeout_nxt = 1'b0;
        if (refresh || !lit_mode(mode)) begin
            timer_nxt = 32'h0; // RQ4
        end else if (timer_r >= TIMEOUT_CYC - 32'h1) begin
            // one-cycle expiry pulse; the count starts again from zero
            timer_nxt = 32'h0;
            timeout_nxt = 1'b1; // RQ4
        end
    end

    // timer state; 32 bits hold 11.2 s of clock cycles with margin
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            timer_r <= 32'h0;
            timeout_r <= 1'b0;
        end else begin
            timer_r <= timer_nxt;
            timeout_r <= timeout_nxt;
        end
    end

    // read mux; force bit shows the pin, unmapped reads give zero
    always @* begin
        case (i_rd_addr)
            `FMT_ADDR_CTRL: rd_nxt = {i_vm_pin, ctrl_r[6:0]}; // RQ2
            `FMT_ADDR_FLASH: rd_nxt = {i_vm_pin, flash_r[6:0]}; // RQ2
            default: rd_nxt = 8'h00;
        endcase
    end

    // registered read data, one cycle after the address
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_rd_data <= 8'h00;
        end else begin
            o_rd_data <= rd_nxt;
        end
    end

    // operating state decode, registered
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_flash_reg <= `FMT_FLASH_RESET;
            o_const_voltage <= 1'b0;
            o_shutdown <= 1'b1;
            o_torch_on <= 1'b0;
            o_flash_arm <= 1'b0;
            o_vreg_mode <= 1'b0;
            o_outer_ma <= 10'd0;
            o_centre_ma <= 10'd0;
            o_timeout <= 1'b0;
        end else begin
            o_flash_reg <= flash_r;
            o_timeout <= timeout_r;
            // force bit or mode 11 means voltage source
            o_const_voltage <= ctrl_r[`FMT_BIT_VMF] || (mode == `FMT_MODE_VSRC); // RQ1 RQ3
            // shutdown only when force and torch enable are both low
            o_shutdown <= (mode == `FMT_MODE_SHDN) && !ctrl_r[`FMT_BIT_VMF]
                && !i_torch_enable; // RQ15
            // stored force bit wins; the pin level only shows on reads
            o_torch_on <= !ctrl_r[`FMT_BIT_VMF] && lit_mode(mode); // RQ3
            o_flash_arm <= !ctrl_r[`FMT_BIT_VMF] && (mode == `FMT_MODE_FLASH); // RQ3
            // both torch codes zero: regulate output voltage instead
            o_vreg_mode <= (ctrl_r[`FMT_OUTER_HI:`FMT_OUTER_LO] == 2'h0)
                && (ctrl_r[`FMT_CENTRE_HI:`FMT_CENTRE_LO] == 3'h0); // RQ12
            o_outer_ma <= outer_ma(ctrl_r[`FMT_OUTER_HI:`FMT_OUTER_LO], VARIANT_B != 0);
            o_centre_ma <= centre_ma(ctrl_r[`FMT_CENTRE_HI:`FMT_CENTRE_LO],
                VARIANT_B != 0, i_tx_mask);
        end
    end

endmodule

// *** fmt_monitor.sv ***
/* checker of the mode and torch register outputs.
   assumes a bind onto fmt_mode_torch_reg; the table variant follows the bound instance. */
module fmt_monitor #(
    parameter VARIANT_B = 0
) (
    input wire i_clk_sys, i_srst, i_wr_stb, i_vm_pin, i_torch_enable, i_tx_mask,
    input wire [7:0] i_wr_addr, i_wr_data, i_rd_addr, o_rd_data, o_flash_reg,
    input wire o_const_voltage, o_shutdown, o_torch_on, o_vreg_mode, o_timeout,
    input wire [9:0] o_centre_ma
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    // ctrl write; a quiet cycle after it keeps a later write out of view
    wire cw = i_wr_stb && i_wr_addr == 8'h01;
    // top centre code without transmit mask, per variant
    wire [9:0] top_ma = (VARIANT_B != 0) ? 10'h113 : 10'h0fa;
    torch_decode_a: assert property (
        cw && i_wr_data[7:5] == 3'h1 ##1 !i_wr_stb |-> ##1 o_torch_on)
        else $error("torch mode not decoded");
    force_vsrc_a: assert property (
        cw && i_wr_data[7] ##1 !i_wr_stb |-> ##1 o_const_voltage && !o_shutdown)
        else $error("force bit not applied");
    mode_mirror_a: assert property (
        cw ##1 !i_wr_stb |-> ##1 o_flash_reg[6:5] == $past(i_wr_data[6:5], 2))
        else $error("mode copy not updated");
    vreg_entry_a: assert property (
        cw && i_wr_data[4:0] == 5'h00 ##1 !i_wr_stb |-> ##1 o_vreg_mode)
        else $error("voltage regulation not entered");
    centre_top_a: assert property (cw && i_wr_data[2:0] == 3'h7 ##1 !i_wr_stb |-> ##1
        o_centre_ma == ($past(i_tx_mask) ? 10'h1f4 : top_ma))
        else $error("centre top code current wrong");
    pin_read_a: assert property (i_rd_addr == 8'h01 |=> o_rd_data[7] == $past(i_vm_pin))
        else $error("read bit7 not pin level");
    shdn_gate_a: assert property (o_shutdown |-> !$past(i_torch_enable) && !o_const_voltage)
        else $error("shutdown while enabled");
    // decoded outputs trail the expiry pulse by one cycle
    timeout_off_a: assert property (o_timeout |=> !o_torch_on && o_flash_reg[6:5] == 2'h0)
        else $error("timeout left torch on");
endmodule
bind fmt_mode_torch_reg fmt_monitor #(.VARIANT_B(VARIANT_B)) fmt_monitor_inst (.*);

// *** fmt_hm.sv ***
/* host model: register writes and read addresses on the falling edge.
   assumes the block takes requests on the rising edge. */
module fmt_hm (
    input wire i_clk_sys,
    output logic o_wr_stb,
    output logic [7:0] o_wr_addr, o_wr_data, o_rd_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus from the start of the run
    initial begin
        {o_wr_stb, o_wr_addr, o_wr_data, o_rd_addr} = {1'b0, 8'h00, 8'h00, 8'h00};
    end
    // one-cycle strobe, then a cycle so decoded outputs have landed
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        {o_wr_stb, o_wr_addr, o_wr_data} = {1'b1, a, d};
        @(negedge i_clk_sys);
        o_wr_stb = 1'b0;
        @(negedge i_clk_sys);
    endtask
    task rd(input logic [7:0] a);
        @(negedge i_clk_sys);
        o_rd_addr = a;
        @(negedge i_clk_sys);
    endtask
endmodule

// *** fmt_mode_torch_reg_bench.sv ***
/* bench: register access sequences with expected values.
   assumes a short safety timer of 100 cycles; checks variant a and variant b tables. */
module fmt_mode_torch_reg_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, vm, ten, txm;
    wire stb, cv, sd, ton, arm, vr, tmo;
    wire [7:0] wa, wd, ra, rdat, fl;
    wire [9:0] oma, cma, oma_b, cma_b;
    int error_cnt = 0, total_checks = 0, n;
    logic [9:0] ot [0:3] = '{10'h000, 10'h032, 10'h04b, 10'h064};
    logic [9:0] ct [0:7] = '{10'h000, 10'h032, 10'h04b, 10'h064, 10'h07d, 10'h096,
        10'h0c8, 10'h0fa};
    logic [9:0] ot_b [0:3] = '{10'h000, 10'h037, 10'h055, 10'h06e};
    logic [9:0] ct_b [0:7] = '{10'h000, 10'h037, 10'h055, 10'h06e, 10'h08c, 10'h0a5,
        10'h0dc, 10'h113};
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    fmt_hm fmt_hm_inst (.i_clk_sys(clk), .o_wr_stb(stb), .o_wr_addr(wa), .o_wr_data(wd),
        .o_rd_addr(ra));
    fmt_mode_torch_reg #(.VARIANT_B(0), .TIMEOUT_CYC(32'd100)) fmt_mode_torch_reg_inst (
        .i_clk_sys(clk), .i_srst(srst), .i_wr_stb(stb), .i_wr_addr(wa), .i_wr_data(wd),
        .i_rd_addr(ra), .o_rd_data(rdat), .i_vm_pin(vm), .i_torch_enable(ten), .i_tx_mask(txm),
        .o_flash_reg(fl), .o_const_voltage(cv), .o_shutdown(sd), .o_torch_on(ton),
        .o_flash_arm(arm), .o_vreg_mode(vr), .o_outer_ma(oma), .o_centre_ma(cma), .o_timeout(tmo));
    // second current table on the same stimulus
    fmt_mode_torch_reg #(.VARIANT_B(1), .TIMEOUT_CYC(32'h64)) fmt_mode_torch_reg_b_inst (
        .i_clk_sys(clk), .i_srst(srst), .i_wr_stb(stb), .i_wr_addr(wa), .i_wr_data(wd),
        .i_rd_addr(ra), .o_rd_data(), .i_vm_pin(vm), .i_torch_enable(ten), .i_tx_mask(txm),
        .o_flash_reg(), .o_const_voltage(), .o_shutdown(), .o_torch_on(),
        .o_flash_arm(), .o_vreg_mode(), .o_outer_ma(oma_b), .o_centre_ma(cma_b), .o_timeout());
    task chk(input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        vm = 1'b0;
        ten = 1'b0;
        txm = 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        chk(sd, 1'b1);
        fmt_hm_inst.rd(8'h01); chk(rdat, 8'h09);
        fmt_hm_inst.rd(8'h02); chk(rdat, 8'h03);
        fmt_hm_inst.rd(8'h07); chk(rdat, 8'h00);
        vm = 1'b1;
        fmt_hm_inst.rd(8'h01); chk(rdat, 8'h89);
        vm = 1'b0;
        // every mode code, with its copy in the flash-current register
        for (int m = 0; m < 4; m++) begin
            fmt_hm_inst.wr(8'h01, {1'b0, m[1:0], 5'h0b});
            chk({sd, ton, arm, cv}, {m == 0, m == 1 || m == 2, m == 2, m == 3});
            chk(fl[6:5], m[1:0]);
        end
        fmt_hm_inst.wr(8'h01, 8'h80); chk({cv, sd}, 2'h2);
        // led channels are already off when both torch codes are zeroed
        fmt_hm_inst.wr(8'h01, 8'h00); chk({sd, vr}, 2'h3);
        ten = 1'b1;
        repeat (2) @(negedge clk);
        chk(sd, 1'b0);
        ten = 1'b0;
        // every current code, transmit mask off and on
        for (int t = 0; t < 2; t++) for (int i = 0; i < 8; i++) begin
            txm = t[0];
            fmt_hm_inst.wr(8'h01, {3'h1, i[1:0], i[2:0]});
            chk(oma, ot[i % 4]);
            chk(cma, (t == 1 && i > 5) ? (i == 6 ? 10'h15e : 10'h1f4) : ct[i]);
            chk(vr, i == 0);
            chk(oma_b, ot_b[i % 4]);
            chk(cma_b, (t == 1 && i > 5) ? (i == 6 ? 10'h15e : 10'h1f4) : ct_b[i]);
        end
        fmt_hm_inst.wr(8'h02, 8'h40); fmt_hm_inst.rd(8'h01); chk(rdat[6:5], 2'h2);
        fmt_hm_inst.wr(8'h03, 8'h00); fmt_hm_inst.rd(8'h01); chk(rdat[6:5], 2'h2);
        // refreshes inside the timer period keep torch alive
        repeat (3) begin
            repeat (60) @(negedge clk);
            fmt_hm_inst.wr(8'h01, 8'h2b);
        end
        chk(ton, 1'b1);
        n = 0;
        while (tmo !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(n > 90 && n < 110, 1'b1);
        // decoded outputs land one cycle after the expiry pulse
        @(negedge clk);
        chk({ton, fl[6:5]}, 3'h0);
        results();
    end
endmodule
